// *** shared/tio_pkg.sv ***
// Shared types and constants of the transducer I/O scaling block.
package tio_pkg;

  // Channel organisation: rows 1 to 8 per slot, grouped in pairs.
  localparam int TIO_NCH = 8;
  localparam int TIO_ROW_W = 4;
  localparam int TIO_PAIR_SIZE = 2;

  // Per-unit fixed point: signed 32 bits with 16 fractional bits.
  localparam int TIO_PU_FRAC = 16;
  localparam logic signed [32:0] TIO_PU_TENTH = 33'sh0_0000_199A;

  // Currents are signed microamps.
  localparam logic signed [31:0] TIO_IN_MIN_UA = -32'sd1000;
  localparam logic signed [31:0] TIO_IN_MAX_UA = 32'sd20000;
  localparam logic signed [31:0] TIO_UA_M1 = -32'sd1000;
  localparam logic signed [31:0] TIO_UA_0 = 32'sd0;
  localparam logic signed [31:0] TIO_UA_P1 = 32'sd1000;
  localparam logic signed [31:0] TIO_UA_4 = 32'sd4000;
  localparam logic signed [31:0] TIO_UA_20 = 32'sd20000;

  // Temperature base for per-unit threshold levels, in degrees Celsius.
  localparam logic [33:0] TIO_RTD_BASE_C = 34'h0_0000_0064;

  // Divider geometry.
  localparam int TIO_DIV_NW = 64;
  localparam int TIO_DIV_DW = 34;

  // Result store layout: word address is {job, channel}.
  localparam int TIO_MEM_AW = 5;
  localparam int TIO_MEM_DW = 32;

  // Teleprotection: sixteen bits per channel, chosen from 64 operands.
  localparam int TIO_TP_BITS = 16;
  localparam int TIO_OPW = 64;

  // Reset values.
  localparam logic [31:0] TIO_RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    TIO_RNG_M1_P1,
    TIO_RNG_4_20,
    TIO_RNG_0_1,
    TIO_RNG_0_20
  } tio_range_t;

  typedef enum logic [1:0] {
    TIO_JOB_OUT,
    TIO_JOB_IN,
    TIO_JOB_RTD
  } tio_job_t;

  typedef struct packed {
    tio_range_t range;
    logic signed [31:0] span_low_limit;
    logic signed [31:0] span_high_limit;
  } tio_out_cfg_t;

  typedef struct packed {
    logic enable;
    tio_range_t input_current_span_select;
    logic signed [31:0] input_primary_low;
    logic signed [31:0] input_primary_high;
  } tio_in_cfg_t;

  typedef struct packed {
    logic [7:0] slot;
    logic [TIO_ROW_W-1:0] row;
  } tio_chan_id_t;

  typedef struct packed {
    tio_job_t kind;
    tio_chan_id_t id;
    logic signed [31:0] value;
    logic inhibit;
    logic valid;
  } tio_result_t;

endpackage : tio_pkg

// *** design/tio_divider.sv ***
// Iterative restoring divider for unsigned operands, one quotient bit per clock.
`timescale 1ns/1ps
module tio_divider #(
  parameter int NW = 64,
  parameter int DW = 34
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Request
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  // Answer
  output logic busy,
  output logic done,
  output logic [NW-1:0] quot
);
  localparam int CW = $clog2(NW + 1);

  logic [DW:0] rem;
  logic [DW:0] shifted;
  logic [DW:0] trial;
  logic [CW-1:0] cnt;

  always_comb begin
    shifted = {rem[DW-1:0], quot[NW-1]};
    trial = shifted - {1'b0, den};
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rem <= '0;
      quot <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      rem <= '0;
      quot <= num;
      cnt <= CW'(NW);
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      // The remainder stays below the divisor, so DW bits always hold it.
      if (!trial[DW]) begin
        rem <= trial;
        quot <= {quot[NW-2:0], 1'b1};
      end else begin
        rem <= shifted;
        quot <= {quot[NW-2:0], 1'b0};
      end
      cnt <= cnt - CW'(1);
      busy <= (cnt != CW'(1));
      done <= (cnt == CW'(1));
    end else begin
      done <= 1'b0;
    end
  end
endmodule : tio_divider

// *** design/tio_result_mem.sv ***
// Small result store with one write port and a registered read port.
`timescale 1ns/1ps
module tio_result_mem #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Words never written read as zero rather than as undefined storage.
  logic [2**AW-1:0] written;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      written <= '0;
    end else if (wr_en) begin
      written[wr_addr] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= written[rd_addr] ? mem[rd_addr] : '0;
    end
  end
endmodule : tio_result_mem

// *** design/tio_scaler.sv ***
// Transducer I/O scaling engine: output scaling, input conversion and teleprotection mapping.
`timescale 1ns/1ps

module tio_scaler import tio_pkg::*; #(
  parameter int NCH = TIO_NCH,
  parameter int TP_BITS = TIO_TP_BITS,
  parameter int OPW = TIO_OPW
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Installed channels, decoded from the module order code
  input wire logic [NCH-1:0] out_installed,
  input wire logic [NCH-1:0] in_installed,
  input wire logic [NCH-1:0] rtd_installed,
  input wire logic [7:0] out_slot,
  input wire logic [7:0] in_slot,
  input wire logic [7:0] rtd_slot,
  // Current-loop output settings and driving quantities
  input wire tio_out_cfg_t out_cfg [NCH],
  input wire logic signed [31:0] output_driving_quantity [NCH],
  // Current-loop input settings and measurements
  input wire tio_in_cfg_t in_cfg [NCH],
  input wire logic signed [15:0] in_current_ua [NCH],
  // Temperature input settings and measurements
  input wire logic [NCH-1:0] rtd_enable,
  input wire logic signed [31:0] rtd_temp_c [NCH],
  // Teleprotection operand selection
  input wire logic [OPW-1:0] tp_operands,
  input wire logic [$clog2(OPW)-1:0] tp_map_ch1 [TP_BITS],
  input wire logic [$clog2(OPW)-1:0] tp_map_ch2 [TP_BITS],
  // Result store read port
  input wire logic [TIO_MEM_AW-1:0] rd_addr,
  output logic [TIO_MEM_DW-1:0] rd_data,
  // Result stream
  output logic res_strobe,
  output tio_result_t res,
  // Channel status
  output logic [NCH-1:0] out_configured,
  output logic [NCH-1:0] in_configured,
  output logic [NCH-1:0] rtd_configured,
  output logic [NCH-1:0] out_inhibit,
  output logic [NCH-1:0] in_valid,
  output logic [NCH-1:0] rtd_valid,
  // Teleprotection outputs
  output logic [TP_BITS-1:0] tp_tx_ch1,
  output logic [TP_BITS-1:0] tp_tx_ch2
);
  localparam int CHW = $clog2(NCH);

  typedef enum logic [1:0] {
    ST_INIT,
    ST_PICK,
    ST_DIV,
    ST_STORE
  } tio_state_t;

  function automatic logic signed [31:0] range_min_ua(input tio_range_t r);
    case (r)
      TIO_RNG_M1_P1: range_min_ua = TIO_UA_M1;
      TIO_RNG_4_20: range_min_ua = TIO_UA_4;
      default: range_min_ua = TIO_UA_0;
    endcase
  endfunction : range_min_ua

  function automatic logic signed [31:0] range_max_ua(input tio_range_t r);
    case (r)
      TIO_RNG_M1_P1: range_max_ua = TIO_UA_P1;
      TIO_RNG_4_20: range_max_ua = TIO_UA_20;
      TIO_RNG_0_1: range_max_ua = TIO_UA_P1;
      default: range_max_ua = TIO_UA_20;
    endcase
  endfunction : range_max_ua

  function automatic logic signed [31:0] clamp(input logic signed [31:0] x, input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    if (x < lo) begin
      clamp = lo;
    end else if (x > hi) begin
      clamp = hi;
    end else begin
      clamp = x;
    end
  endfunction : clamp

  function automatic logic [63:0] magnitude(input logic signed [63:0] v);
    magnitude = v[63] ? 64'(-v) : 64'(v);
  endfunction : magnitude

  function automatic logic [TP_BITS-1:0] tp_pick(input logic [OPW-1:0] ops,
                                                  input logic [$clog2(OPW)-1:0] map [TP_BITS]);
    tp_pick = '0;
    for (int i = 0; i < TP_BITS; i++) begin
      tp_pick[i] = ops[map[i]];
    end
  endfunction : tp_pick

  tio_state_t state;
  tio_job_t job;
  logic [CHW-1:0] ch;
  logic [NCH-1:0] out_present;
  logic [NCH-1:0] in_present;
  logic [NCH-1:0] rtd_present;

  // Operands of the current channel, computed from its settings.
  logic signed [31:0] rmin;
  logic signed [31:0] rmax;
  logic signed [32:0] lim_diff;
  logic signed [31:0] x_clamped;
  logic [32:0] x_offset;
  logic signed [31:0] i_clamped;
  logic signed [63:0] in_prod;
  logic [63:0] calc_num;
  logic [TIO_DIV_DW-1:0] calc_den;
  logic calc_neg;
  logic signed [31:0] calc_base;
  logic calc_inh;
  logic calc_valid;
  logic chan_present;

  // Operands held while the divider runs.
  logic hold_neg;
  logic signed [31:0] hold_base;
  logic hold_inh;
  logic hold_valid;
  logic signed [31:0] hold_value;

  logic div_start;
  logic div_done;
  logic [63:0] div_quot;
  logic signed [31:0] next_value;

  always_comb begin
    rmin = TIO_UA_0;
    rmax = TIO_UA_0;
    lim_diff = '0;
    x_clamped = '0;
    x_offset = '0;
    i_clamped = '0;
    in_prod = '0;
    calc_num = '0;
    calc_den = '0;
    calc_neg = 1'b0;
    calc_base = '0;
    calc_inh = 1'b0;
    calc_valid = 1'b0;
    chan_present = 1'b0;
    case (job)
      TIO_JOB_OUT: begin
        chan_present = out_present[ch];
        rmin = range_min_ua(out_cfg[ch].range);
        rmax = range_max_ua(out_cfg[ch].range);
        lim_diff = 33'(out_cfg[ch].span_high_limit) - 33'(out_cfg[ch].span_low_limit);
        // The fourth range code is offered to inputs only, so an output set to it is held off as well.
        calc_inh = (lim_diff < TIO_PU_TENTH) || (out_cfg[ch].range == TIO_RNG_0_20);
        x_clamped = clamp(output_driving_quantity[ch], out_cfg[ch].span_low_limit,
                          out_cfg[ch].span_high_limit);
        x_offset = 33'(x_clamped) - 33'(out_cfg[ch].span_low_limit);
        // Dividing the product rather than a precomputed gain keeps the error within one microamp.
        calc_num = 64'(x_offset) * 64'(32'(rmax - rmin));
        calc_den = TIO_DIV_DW'(lim_diff);
        calc_base = rmin;
        calc_valid = !calc_inh;
      end
      TIO_JOB_IN: begin
        chan_present = in_present[ch];
        rmin = range_min_ua(in_cfg[ch].input_current_span_select);
        rmax = range_max_ua(in_cfg[ch].input_current_span_select);
        i_clamped = clamp(32'(in_current_ua[ch]), TIO_IN_MIN_UA, TIO_IN_MAX_UA);
        in_prod = 64'(i_clamped - rmin) * (64'(in_cfg[ch].input_primary_high) -
                                          64'(in_cfg[ch].input_primary_low));
        calc_neg = in_prod[63];
        calc_num = magnitude(in_prod);
        calc_den = TIO_DIV_DW'(32'(rmax - rmin));
        calc_base = in_cfg[ch].input_primary_low;
        calc_valid = in_cfg[ch].enable;
      end
      TIO_JOB_RTD: begin
        chan_present = rtd_present[ch];
        calc_neg = rtd_temp_c[ch][31];
        calc_num = magnitude(64'(rtd_temp_c[ch]));
        calc_den = TIO_RTD_BASE_C;
        calc_valid = rtd_enable[ch];
      end
      default: begin
        chan_present = 1'b0;
      end
    endcase
  end

  assign div_start = (state == ST_PICK) && chan_present && calc_valid;
  assign next_value = hold_base + (hold_neg ? -div_quot[31:0] : div_quot[31:0]);

  tio_divider #(
    .NW(TIO_DIV_NW),
    .DW(TIO_DIV_DW)
  ) u_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(div_start),
    .num(calc_num),
    .den(calc_den),
    .busy(),
    .done(div_done),
    .quot(div_quot)
  );

  // Installed channels are captured once after reset and then scanned in a fixed round.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_present <= '0;
      in_present <= '0;
      rtd_present <= '0;
    end else if (state == ST_INIT) begin
      out_present <= out_installed;
      in_present <= in_installed;
      rtd_present <= rtd_installed;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_INIT;
      job <= TIO_JOB_OUT;
      ch <= '0;
      hold_neg <= 1'b0;
      hold_base <= '0;
      hold_inh <= 1'b0;
      hold_valid <= 1'b0;
      hold_value <= '0;
    end else begin
      case (state)
        ST_INIT: begin
          state <= ST_PICK;
        end
        ST_PICK: begin
          hold_neg <= calc_neg;
          hold_base <= calc_base;
          hold_inh <= calc_inh;
          hold_valid <= calc_valid;
          hold_value <= '0;
          if (!chan_present) begin
            if (ch == CHW'(NCH - 1)) begin
              job <= (job == TIO_JOB_RTD) ? TIO_JOB_OUT : tio_job_t'(job + 2'h1);
            end
            ch <= (ch == CHW'(NCH - 1)) ? '0 : ch + CHW'(1);
          end else if (calc_valid) begin
            state <= ST_DIV;
          end else begin
            // Inhibited or disabled: no division, the store step updates status and the result stream and writes zero for an output.
            state <= ST_STORE;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            hold_value <= next_value;
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (ch == CHW'(NCH - 1)) begin
            job <= (job == TIO_JOB_RTD) ? TIO_JOB_OUT : tio_job_t'(job + 2'h1);
          end
          ch <= (ch == CHW'(NCH - 1)) ? '0 : ch + CHW'(1);
          state <= ST_PICK;
        end
        default: begin
          state <= ST_INIT;
        end
      endcase
    end
  end

  // The store keeps only real values; an inhibited output parks at zero current.
  tio_result_mem #(
    .AW(TIO_MEM_AW),
    .DW(TIO_MEM_DW)
  ) u_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(state == ST_STORE && (hold_valid || job == TIO_JOB_OUT)),
    .wr_addr({job, ch}),
    .wr_data(hold_valid ? hold_value : TIO_RST_WORD),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_strobe <= 1'b0;
      res <= '0;
    end else begin
      res_strobe <= (state == ST_STORE);
      if (state == ST_STORE) begin
        res.kind <= job;
        res.id.slot <= (job == TIO_JOB_OUT) ? out_slot : (job == TIO_JOB_IN) ? in_slot : rtd_slot;
        res.id.row <= TIO_ROW_W'(ch) + TIO_ROW_W'(1);
        res.value <= hold_valid ? hold_value : TIO_RST_WORD;
        res.inhibit <= hold_inh;
        res.valid <= hold_valid;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_inhibit <= '0;
      in_valid <= '0;
      rtd_valid <= '0;
    end else if (state == ST_STORE) begin
      case (job)
        TIO_JOB_OUT: out_inhibit[ch] <= hold_inh;
        TIO_JOB_IN: in_valid[ch] <= hold_valid;
        TIO_JOB_RTD: rtd_valid[ch] <= hold_valid;
        default: out_inhibit <= out_inhibit;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_configured <= '0;
      in_configured <= '0;
      rtd_configured <= '0;
    end else if (state == ST_PICK) begin
      out_configured <= out_present;
      in_configured <= in_present;
      rtd_configured <= rtd_present;
    end
  end

  // Each channel has its own map and is refreshed every clock, so losing one never disturbs the other.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tp_tx_ch1 <= '0;
    end else begin
      tp_tx_ch1 <= tp_pick(tp_operands, tp_map_ch1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tp_tx_ch2 <= '0;
    end else begin
      tp_tx_ch2 <= tp_pick(tp_operands, tp_map_ch2);
    end
  end

endmodule : tio_scaler

// *** dv/tio_transducers.sv ***
// Behavioural far side: fixed loop currents and temperatures from the field.
`timescale 1ns/1ps
module tio_transducers import tio_pkg::*; (
  // Measurements
  output logic signed [15:0] in_current_ua [TIO_NCH],
  output logic signed [31:0] rtd_temp_c [TIO_NCH]
);
  // Loop currents stay inside the span the input path accepts, both ends included.
  always_comb begin
    for (int i = 0; i < TIO_NCH; i++) begin
      in_current_ua[i] = 16'sh4E20;
      rtd_temp_c[i] = 32'sh0000_0000;
    end
    in_current_ua[0] = 16'sh2EE0;
    in_current_ua[2] = -16'sh03E8;
    rtd_temp_c[0] = 32'sh0096_0000;
    rtd_temp_c[1] = 32'sh001E_0000;
  end
endmodule : tio_transducers

// *** dv/tio_scaler_asserts.sv ***
// Concurrent checks on the ports of the scaling engine.
`timescale 1ns/1ps
module tio_scaler_asserts import tio_pkg::*; #(
  parameter int NCH = TIO_NCH,
  parameter int TP_BITS = TIO_TP_BITS,
  parameter int OPW = TIO_OPW
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Settings and operands
  input wire logic [NCH-1:0] out_installed,
  input wire tio_out_cfg_t out_cfg [NCH],
  input wire logic signed [31:0] output_driving_quantity [NCH],
  input wire tio_in_cfg_t in_cfg [NCH],
  input wire logic [NCH-1:0] rtd_enable,
  input wire logic [OPW-1:0] tp_operands,
  input wire logic [$clog2(OPW)-1:0] tp_map_ch1 [TP_BITS],
  input wire logic [$clog2(OPW)-1:0] tp_map_ch2 [TP_BITS],
  // Results
  input wire logic res_strobe,
  input wire tio_result_t res,
  input wire logic [NCH-1:0] out_configured,
  input wire logic [NCH-1:0] out_inhibit,
  input wire logic [NCH-1:0] rtd_valid,
  input wire logic [TP_BITS-1:0] tp_tx_ch1,
  input wire logic [TP_BITS-1:0] tp_tx_ch2
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [2:0] cyc;
  logic [2:0] ch;
  tio_out_cfg_t oc;
  logic signed [31:0] ox;
  logic signed [32:0] ospan;
  function automatic logic signed [31:0] rmin(input tio_range_t r);
    case (r)
      TIO_RNG_M1_P1: return TIO_UA_M1;
      TIO_RNG_4_20: return TIO_UA_4;
      default: return TIO_UA_0;
    endcase
  endfunction : rmin
  function automatic logic signed [31:0] rmax(input tio_range_t r);
    case (r)
      TIO_RNG_4_20: return TIO_UA_20;
      TIO_RNG_0_20: return TIO_UA_20;
      default: return TIO_UA_P1;
    endcase
  endfunction : rmax
  // Counts edges since reset release so the captured masks are judged once they have settled.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc <= 3'h0;
    end else if (cyc != 3'h7) begin
      cyc <= cyc + 3'h1;
    end
  end
  assign ch = res.id.row[2:0] - 3'h1;
  assign oc = out_cfg[ch];
  assign ox = output_driving_quantity[ch];
  assign ospan = {oc.span_high_limit[31], oc.span_high_limit} - {oc.span_low_limit[31], oc.span_low_limit};
  row_range_a: assert property (res_strobe |-> res.id.row inside {[4'h1:4'h8]})
    else $error("result row outside one to eight");
  inh_span_a: assert property (res_strobe && res.kind == TIO_JOB_OUT |->
    res.inhibit == (ospan < TIO_PU_TENTH || oc.range == TIO_RNG_0_20)) else $error("inhibit not from span");
  inh_zero_a: assert property (res_strobe && res.inhibit |-> res.value == 32'h0 && !res.valid)
    else $error("inhibited result carries a value");
  inh_status_a: assert property (res_strobe && res.kind == TIO_JOB_OUT |-> out_inhibit[ch] == res.inhibit)
    else $error("inhibit mask disagrees with result");
  out_bounds_a: assert property (res_strobe && res.kind == TIO_JOB_OUT && !res.inhibit |->
    res.value >= rmin(oc.range) && res.value <= rmax(oc.range)) else $error("output outside range");
  out_clamp_a: assert property (res_strobe && res.kind == TIO_JOB_OUT && !res.inhibit |->
    (ox > oc.span_low_limit || res.value == rmin(oc.range)) && (ox < oc.span_high_limit || res.value == rmax(oc.range)))
    else $error("clamped output not at range end");
  in_off_a: assert property (res_strobe && res.kind == TIO_JOB_IN && !in_cfg[ch].enable |-> !res.valid)
    else $error("disabled input gave a value");
  rtd_valid_a: assert property (res_strobe && res.kind == TIO_JOB_RTD |->
    res.valid == rtd_enable[ch] ##1 rtd_valid[ch] == res.valid) else $error("temperature validity wrong");
  cfg_mask_a: assert property (cyc == 3'h5 |-> out_configured == out_installed)
    else $error("configured mask differs from installed");
  for (genvar i = 0; i < TP_BITS; i++) begin : g_tp
    tp_ch1_a: assert property ($past(arst_n) |-> tp_tx_ch1[i] == $past(tp_operands[tp_map_ch1[i]]))
      else $error("first channel bit wrong");
    tp_ch2_a: assert property ($past(arst_n) |-> tp_tx_ch2[i] == $past(tp_operands[tp_map_ch2[i]]))
      else $error("second channel bit wrong");
  end
  cov_out_c: cover property (res_strobe && res.kind == TIO_JOB_OUT && !res.inhibit);
  cov_inh_c: cover property (res_strobe && res.inhibit);
  cov_rtd_c: cover property (res_strobe && res.kind == TIO_JOB_RTD && res.valid);
endmodule : tio_scaler_asserts

bind tio_scaler tio_scaler_asserts #(.NCH(NCH), .TP_BITS(TP_BITS), .OPW(OPW)) u_asserts (
  .ref_clk, .arst_n, .out_installed, .out_cfg, .output_driving_quantity, .in_cfg, .rtd_enable,
  .tp_operands, .tp_map_ch1, .tp_map_ch2, .res_strobe, .res, .out_configured, .out_inhibit,
  .rtd_valid, .tp_tx_ch1, .tp_tx_ch2);

// *** dv/tio_scaler_bench.sv ***
// Self-checking bench for the transducer scaling engine.
`timescale 1ns/1ps
module tio_scaler_bench import tio_pkg::*; ;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  tio_out_cfg_t ocfg [8];
  logic signed [31:0] oq [8];
  tio_in_cfg_t icfg [8];
  logic signed [15:0] cur [8];
  logic signed [31:0] temp [8];
  logic [63:0] ops = 64'h0;
  logic [7:0] o_inst = 8'h3F;
  logic [7:0] r_en = 8'h01;
  logic [5:0] m1 [16];
  logic [5:0] m2 [16];
  logic [4:0] rd_addr = 5'h00;
  logic [31:0] rd_data;
  logic res_strobe;
  tio_result_t res;
  logic [7:0] o_cfgd;
  logic [7:0] i_cfgd;
  logic [7:0] r_cfgd;
  logic [7:0] o_inh;
  logic [7:0] i_val;
  logic [7:0] r_val;
  logic [15:0] tx1;
  logic [15:0] tx2;
  tio_result_t cap [24];
  logic got [24];
  int bad_count = 0;
  int n_checks = 0;

  tio_scaler uut (.ref_clk(ref_clk), .arst_n(arst_n), .out_installed(o_inst), .in_installed(8'h07),
    .rtd_installed(8'h03), .out_slot(8'h46), .in_slot(8'h48), .rtd_slot(8'h4D), .out_cfg(ocfg),
    .output_driving_quantity(oq), .in_cfg(icfg), .in_current_ua(cur), .rtd_enable(r_en),
    .rtd_temp_c(temp), .tp_operands(ops), .tp_map_ch1(m1), .tp_map_ch2(m2), .rd_addr(rd_addr),
    .rd_data(rd_data), .res_strobe(res_strobe), .res(res), .out_configured(o_cfgd),
    .in_configured(i_cfgd), .rtd_configured(r_cfgd), .out_inhibit(o_inh), .in_valid(i_val),
    .rtd_valid(r_val), .tp_tx_ch1(tx1), .tp_tx_ch2(tx2));
  tio_transducers u_xdcr (.in_current_ua(cur), .rtd_temp_c(temp));

  always #2.5 ref_clk = ~ref_clk;

  // Keeps the latest result of every channel, indexed by kind and row.
  always @(posedge ref_clk) begin
    if (res_strobe) begin
      got[8 * int'(res.kind) + int'(res.id.row) - 1] <= 1'b1;
      cap[8 * int'(res.kind) + int'(res.id.row) - 1] <= res;
    end
  end

  task automatic chk_word(input logic [31:0] act, input logic [31:0] exp);
    n_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk_word

  task automatic chk_mask(input logic [7:0] act, input logic [7:0] exp);
    chk_word({24'h0, act}, {24'h0, exp});
  endtask : chk_mask

  task automatic chk_res(input int k, input logic [7:0] slot, input logic [31:0] val, input logic [1:0] iv);
    int n;
    for (n = 0; n < 4000 && got[k] !== 1'b1; n++) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_word(cap[k].value, val);
    chk_word({20'h0, cap[k].id}, {20'h0, slot, 4'(k % 8 + 1)});
    chk_word({30'h0, cap[k].inhibit, cap[k].valid}, {30'h0, iv});
  endtask : chk_res

  task automatic test_outputs();
    chk_res(0, 8'h46, 32'h0000_01F4, 2'b01);
    chk_res(1, 8'h46, 32'h0000_0FA0, 2'b01);
    chk_res(2, 8'h46, 32'h0000_03E8, 2'b01);
    chk_res(3, 8'h46, 32'h0000_2EE0, 2'b01);
    chk_res(4, 8'h46, 32'h0000_0000, 2'b10);
    chk_res(5, 8'h46, 32'h0000_0000, 2'b10);
    chk_mask(o_inh, 8'h30);
    $display("test_outputs done");
  endtask : test_outputs

  task automatic test_inputs();
    chk_res(8, 8'h48, 32'h0000_007D, 2'b01);
    chk_res(9, 8'h48, 32'h0000_0000, 2'b00);
    chk_res(10, 8'h48, 32'hFFFF_FFCE, 2'b01);
    chk_mask(i_val, 8'h05);
    $display("test_inputs done");
  endtask : test_inputs

  task automatic test_rtd();
    chk_res(16, 8'h4D, 32'h0001_8000, 2'b01);
    chk_res(17, 8'h4D, 32'h0000_0000, 2'b00);
    chk_mask(r_val, 8'h01);
    // Enabling the second channel must give it a value on its next scan.
    @(negedge ref_clk);
    r_en = 8'h03;
    got[17] = 1'b0;
    chk_res(17, 8'h4D, 32'h0000_4CCC, 2'b01);
    chk_mask(r_val, 8'h03);
    $display("test_rtd done");
  endtask : test_rtd

  task automatic test_config();
    chk_mask(o_cfgd, 8'h3F);
    chk_mask(i_cfgd, 8'h07);
    chk_mask(r_cfgd, 8'h03);
    chk_word({31'h0, got[6]}, 32'h0);
    $display("test_config done");
  endtask : test_config

  task automatic test_store();
    logic [4:0] a [5] = '{5'h00, 5'h04, 5'h11, 5'h0A, 5'h06};
    logic [31:0] e [5] = '{32'h0000_01F4, 32'h0, 32'h0000_4CCC, 32'hFFFF_FFCE, 32'h0};
    for (int i = 0; i < 5; i++) begin
      @(negedge ref_clk);
      rd_addr = a[i];
      @(negedge ref_clk);
      chk_word(rd_data, e[i]);
    end
    $display("test_store done");
  endtask : test_store

  task automatic test_teleprot();
    logic [63:0] pat [2] = '{64'hF0F0_1234_8000_0001, 64'h0F0F_EDCB_7FFF_FFFE};
    logic [15:0] e1;
    logic [15:0] e2;
    for (int p = 0; p < 2; p++) begin
      @(negedge ref_clk);
      ops = pat[p];
      for (int i = 0; i < 16; i++) begin
        e1[i] = pat[p][i];
        e2[i] = pat[p][63 - i];
      end
      @(negedge ref_clk);
      chk_word({16'h0, tx1}, {16'h0, e1});
      chk_word({16'h0, tx2}, {16'h0, e2});
    end
    $display("test_teleprot done");
  endtask : test_teleprot

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    for (int i = 0; i < 24; i++) begin
      got[i] = 1'b0;
      if (i < 16) begin
        m1[i] = 6'(i);
        m2[i] = 6'(63 - i);
      end
      if (i < 8) begin
        ocfg[i] = '{TIO_RNG_4_20, 32'sh0, 32'sh0001_0000};
        oq[i] = 32'sh0;
        icfg[i] = '{1'b1, TIO_RNG_0_20, 32'sh0, 32'sh0000_03E8};
      end
    end
    ocfg[0] = '{TIO_RNG_M1_P1, -32'sh0001_0000, 32'sh0001_0000};
    oq[0] = 32'sh0000_8000;
    oq[1] = -32'sh0001_0000;
    ocfg[2] = '{TIO_RNG_0_1, 32'sh0, 32'sh0001_0000};
    oq[2] = 32'sh0002_0000;
    ocfg[3] = '{TIO_RNG_4_20, 32'sh0, 32'sh0000_199A};
    oq[3] = 32'sh0000_0CCD;
    ocfg[4] = '{TIO_RNG_M1_P1, 32'sh0, 32'sh0000_1999};
    ocfg[5] = '{TIO_RNG_0_20, 32'sh0, 32'sh0001_0000};
    icfg[0] = '{1'b1, TIO_RNG_4_20, 32'sh0, 32'sh0000_00FA};
    icfg[1] = '{1'b0, TIO_RNG_M1_P1, -32'sh14, 32'sh0000_00B4};
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    test_outputs();
    test_inputs();
    test_rtd();
    test_config();
    test_store();
    test_teleprot();
    test_done();
  end

  // A full scan pass takes under 2000 cycles; ten times that means a hang.
  initial begin
    #(5 * 20000);
    $display("watchdog expired");
    bad_count++;
    test_done();
  end
endmodule : tio_scaler_bench
